// *** include/cam_pkg.sv ***
// Constants, mode enumeration and decode helpers for the counter array
// module modes.
// Assumes a single counter clock domain and pin inputs synchronous to it.
package cam_pkg;
    localparam int NUM_MODULES     = 8;
    localparam int CAPTURE_MODULES = 6;

    localparam logic [1:0] RES_8  = 2'h0;
    localparam logic [1:0] RES_10 = 2'h1;
    localparam logic [1:0] RES_12 = 2'h2;
    localparam logic [1:0] RES_16 = 2'h3;

    localparam int AUX_ACTIVE_BIT = 0;
    localparam int AUX_RELOAD_BIT = 1;

    localparam logic [15:0] COUNTER_RESET  = 16'h0000;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
    localparam logic [15:0] COUNT_STEP     = 16'h0001;
    localparam logic [7:0]  MATCH_RESET    = 8'h00;
    localparam logic [16:0] CMP_RESET      = 17'h00000;
    localparam logic [16:0] CMP_ONE        = 17'h00001;
    localparam logic [1:0]  PRIME_RESET    = 2'h0;

    typedef enum logic [2:0] {
        MODE_IDLE,
        MODE_CAPTURE,
        MODE_TIMER,
        MODE_TOGGLE_MATCH,
        MODE_PWM,
        MODE_TOGGLE_PWM,
        MODE_FIFO
    } cam_mode_e;

    // Turns the six mode bits of one module into its operating mode.
    function automatic cam_mode_e cam_decode(
        input logic ecom,
        input logic rise,
        input logic fall,
        input logic mat,
        input logic tog,
        input logic pwm
    );
        cam_mode_e m;
        m = MODE_IDLE;
        if (pwm && ecom && !mat && !rise)
        begin
            if (fall && !tog)
                m = MODE_FIFO;
            else if (!fall && tog)
                m = MODE_TOGGLE_PWM;
            else if (!fall)
                m = MODE_PWM;
        end
        else if (!pwm && ecom && mat && !rise && !fall)
            m = tog ? MODE_TOGGLE_MATCH : MODE_TIMER;
        else if (!pwm && !mat && !tog && (rise || fall))
            m = MODE_CAPTURE;
        return m;
    endfunction

    // Counter bits that take part in a comparison at a given resolution.
    function automatic logic [15:0] cam_res_mask(input logic [1:0] sel);
        logic [15:0] m;
        m = 16'h00FF;
        unique case (sel)
            RES_8:  m = 16'h00FF;
            RES_10: m = 16'h03FF;
            RES_12: m = 16'h0FFF;
            RES_16: m = 16'hFFFF;
        endcase
        return m;
    endfunction
endpackage

// *** core/cam_edge_det.sv ***
// Pin sampler and edge detector for one counter array module.
// Assumes the pin is already synchronous to core_clk.
`timescale 1ns/100ps
module cam_edge_det (
    input  logic core_clk,
    input  logic rst,
    input  logic pinIn,
    output logic rise,
    output logic fall
);
    logic       sample_r;
    logic       prev_r;
    logic [1:0] primed_r;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sample_r <= 1'b0;
            prev_r   <= 1'b0;
            primed_r <= cam_pkg::PRIME_RESET;
        end
        else
        begin
            sample_r <= pinIn;
            prev_r   <= sample_r;
            primed_r <= {primed_r[0], 1'b1};
        end
    end

    // Edges count only once two real samples exist, so reset is no edge.
    assign rise = primed_r[1] && sample_r && !prev_r;
    assign fall = primed_r[1] && !sample_r && prev_r;
endmodule // cam_edge_det

// *** core/cam_modes.sv ***
// Shared counter and eight compare/PWM modules, six of them with capture, of a counter array.
// Assumes software drives the mode bits and byte writes as plain ports,
// synchronous to core_clk, and pulses the timer overflow inputs.
//
// Operation
// - Rise, fall or both edges trigger capture.
// - Capture copies counter bytes into match value.
// - Interrupt request equals hit flag and enable.
// - Modules six and seven never capture.
// - Odd module buffers paired even module captures.
// - Each pair has its own buffer enable.
// - Counter equal to match value sets flag.
// - Toggle-on-match flips pin on every match.
// - PWM needs pulse and comparator enables.
// - Pin low below compare value, else high.
// - Low-byte wrap reloads active compare value.
// - Reload zero is full duty, 0x100 none.
// - Resolution code zero selects buffered eight-bit.
// - Each module runs its own PWM resolution.
// - Buffered wide PWM updates at period end.
// - PWM-match toggle uses resolution comparator.
// - Paired toggle: even starts, odd ends pulse.
// - Pair six/seven has its own buffer enable.
// - FIFO mode chains two modules' match values.
// - Step shifts queue; overflow reloads compare.
// - Two-bit code picks the FIFO step source.
// - Resolution sets where the period overflows.
// - Hit flag stays set until software clears.
`timescale 1ns/100ps
module cam_modes (
    input  logic        core_clk,
    input  logic        rst,
    input  logic        counterRun,
    input  logic [7:0]  comparatorEnable,
    input  logic [7:0]  riseEdgeGrabEnable,
    input  logic [7:0]  fallEdgeGrabEnable,
    input  logic [7:0]  compareHitFlagEnable,
    input  logic [7:0]  pinFlipOnHit,
    input  logic [7:0]  pulseModEnable,
    input  logic [7:0]  hitIrqEnable,
    input  logic [15:0] pwmResolutionSel,
    input  logic        pair01BufferEnable,
    input  logic        pair23BufferEnable,
    input  logic        pair45BufferEnable,
    input  logic        pair67BufferEnable,
    input  logic [1:0]  fifoStepSourceSel,
    input  logic        timer0Overflow,
    input  logic        timer1Overflow,
    input  logic        timer3Overflow,
    input  logic        serial0TimerOverflow,
    input  logic [7:0]  wrData,
    input  logic [7:0]  lowWrEn,
    input  logic [7:0]  highWrEn,
    input  logic [7:0]  auxWrEn,
    input  logic [1:0]  auxWrData,
    input  logic [7:0]  hitFlagClr,
    input  logic [7:0]  modulePinIn,
    output logic [7:0]  modulePinOut,
    output logic [7:0]  modulePinOe_n,
    output logic [63:0] matchLowOut,
    output logic [63:0] matchHighOut,
    output logic [7:0]  activeNinthOut,
    output logic [7:0]  reloadNinthOut,
    output logic [7:0]  hitFlag,
    output logic [7:0]  hitIrq,
    output logic [7:0]  counterHigh,
    output logic [7:0]  counterLow
);
    localparam int NUM = cam_pkg::NUM_MODULES;

    logic [15:0]       counter_r;
    logic              cntAdv_r;
    logic [3:0]        pairEn;
    logic [3:0]        stepSources;
    logic              fifoStep;
    logic [7:0]        matchLow_r  [NUM];
    logic [7:0]        matchHigh_r [NUM];
    logic [7:0]        activeNinth_r;
    logic [7:0]        reloadNinth_r;
    logic [7:0]        hitFlag_r;
    logic [7:0]        pinOut_r;
    logic [7:0]        captureEv;
    logic [7:0]        pwmMatch;
    logic [7:0]        fifoActive;
    cam_pkg::cam_mode_e modeOf [NUM];

    assign pairEn = {pair67BufferEnable, pair45BufferEnable,
                     pair23BufferEnable, pair01BufferEnable};

    assign stepSources = {serial0TimerOverflow, timer3Overflow,
                          timer1Overflow, timer0Overflow};
    assign fifoStep    = stepSources[fifoStepSourceSel];

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            counter_r <= cam_pkg::COUNTER_RESET;
            cntAdv_r  <= 1'b0;
        end
        else
        begin
            counter_r <= counterRun ? counter_r + cam_pkg::COUNT_STEP
                                    : counter_r;
            cntAdv_r  <= counterRun;
        end
    end

    assign counterHigh   = counter_r[15:8];
    assign counterLow    = counter_r[7:0];
    assign hitFlag       = hitFlag_r;
    assign modulePinOut  = pinOut_r;
    assign activeNinthOut = activeNinth_r;
    assign reloadNinthOut = reloadNinth_r;

    for (genvar i = 0; i < NUM; i++)
    begin : g_mod
        localparam int P       = i ^ 1;
        localparam bit IS_ODD  = (i % 2 == 1);
        localparam bit HAS_CAP = (i < cam_pkg::CAPTURE_MODULES);

        logic        rise;
        logic        fall;
        logic        capMode;
        logic        pwmish;
        logic        res8;
        logic        pairOn;
        logic        useShadow;
        logic        ovf;
        logic        hitEq;
        logic        hitSet;
        logic        pwmLevel;
        logic        reload8;
        logic        bufIn;
        logic        fifoIntoLow;
        logic        fifoIntoHigh;
        logic        pairedToggle;
        logic        pinNxt;
        logic        flagNxt;
        logic        ninthNxt;
        logic [1:0]  resSel;
        logic [15:0] resMask;
        logic [15:0] matchWord;
        logic [16:0] extPos;
        logic [16:0] cmpDirect;
        logic [16:0] cmpVal;
        logic [16:0] cntMasked;
        logic [16:0] activeCmp_r;
        logic [7:0]  lowNxt;
        logic [7:0]  highNxt;

        cam_edge_det u_edge (
            .core_clk (core_clk),
            .rst      (rst),
            .pinIn    (modulePinIn[i]),
            .rise     (rise),
            .fall     (fall)
        );

        assign modeOf[i] = cam_pkg::cam_decode(comparatorEnable[i],
            riseEdgeGrabEnable[i], fallEdgeGrabEnable[i],
            compareHitFlagEnable[i], pinFlipOnHit[i], pulseModEnable[i]);

        assign capMode = HAS_CAP && modeOf[i] == cam_pkg::MODE_CAPTURE;
        assign captureEv[i] = capMode &&
            ((rise && riseEdgeGrabEnable[i]) ||
             (fall && fallEdgeGrabEnable[i]));

        assign pwmish = modeOf[i] == cam_pkg::MODE_PWM ||
                        modeOf[i] == cam_pkg::MODE_TOGGLE_PWM ||
                        modeOf[i] == cam_pkg::MODE_FIFO;
        assign pairOn     = pairEn[i / 2];
        assign fifoActive[i] = !IS_ODD &&
                               modeOf[i] == cam_pkg::MODE_FIFO;

        assign resSel  = pwmResolutionSel[2 * i +: 2];
        assign res8    = resSel == cam_pkg::RES_8;
        assign resMask = cam_pkg::cam_res_mask(resSel);
        assign ovf     = counterRun &&
            ((counter_r | ~resMask) == cam_pkg::COUNT_ALL_ONES);

        // The extension bit sits just above the active resolution.
        assign matchWord = {matchHigh_r[i], matchLow_r[i]};
        assign extPos    = {1'b0, resMask} + cam_pkg::CMP_ONE;
        assign cmpDirect = {1'b0, matchWord & resMask} |
            (activeNinth_r[i] ? extPos : cam_pkg::CMP_RESET);
        assign useShadow = pwmish && !res8 &&
                           (pairOn || fifoActive[i]);
        assign cmpVal    = useShadow ? activeCmp_r : cmpDirect;
        assign cntMasked = {1'b0, counter_r & resMask};

        // Compare value zero keeps the pin high, one past the top keeps
        // it low, so the full 0 to 100 percent range is reachable.
        assign pwmLevel    = cntMasked >= cmpVal;
        assign pwmMatch[i] = cntAdv_r && cntMasked == cmpVal;
        assign hitEq       = cntAdv_r && counter_r == matchWord;

        assign reload8      = pwmish && res8 && ovf;
        assign bufIn        = IS_ODD && pairOn && captureEv[P];
        assign fifoIntoLow  = IS_ODD && fifoActive[P] && fifoStep;
        assign fifoIntoHigh = fifoActive[i] && fifoStep;
        assign pairedToggle = !IS_ODD && pairOn &&
                              modeOf[i] == cam_pkg::MODE_TOGGLE_PWM;

        assign hitSet  = captureEv[i] ||
                         (compareHitFlagEnable[i] && hitEq);
        assign flagNxt = hitSet || (hitFlag_r[i] && !hitFlagClr[i]);

        assign pinNxt =
            modeOf[i] == cam_pkg::MODE_TOGGLE_MATCH ?
                pinOut_r[i] ^ hitEq :
            pairedToggle ?
                (pwmMatch[i] ? 1'b1 :
                 pwmMatch[P] ? 1'b0 : pinOut_r[i]) :
            modeOf[i] == cam_pkg::MODE_TOGGLE_PWM ?
                pinOut_r[i] ^ pwmMatch[i] :
            pwmish ? pwmLevel : pinOut_r[i];

        assign lowNxt =
            lowWrEn[i]   ? wrData :
            captureEv[i] ? counter_r[7:0] :
            bufIn        ? matchLow_r[P] :
            fifoIntoLow  ? matchHigh_r[i] :
            reload8      ? matchHigh_r[i] : matchLow_r[i];

        assign highNxt =
            highWrEn[i]  ? wrData :
            captureEv[i] ? counter_r[15:8] :
            bufIn        ? matchHigh_r[P] :
            fifoIntoHigh ? matchLow_r[P] : matchHigh_r[i];

        assign ninthNxt =
            auxWrEn[i] ? auxWrData[cam_pkg::AUX_ACTIVE_BIT] :
            reload8    ? reloadNinth_r[i] : activeNinth_r[i];

        assign hitIrq[i] = hitFlag_r[i] && hitIrqEnable[i];
        assign modulePinOe_n[i] =
            !(pwmish || modeOf[i] == cam_pkg::MODE_TOGGLE_MATCH);
        assign matchLowOut[8 * i +: 8]  = matchLow_r[i];
        assign matchHighOut[8 * i +: 8] = matchHigh_r[i];

        always_ff @(posedge core_clk or posedge rst)
        begin
            if (rst)
            begin
                matchLow_r[i]    <= cam_pkg::MATCH_RESET;
                matchHigh_r[i]   <= cam_pkg::MATCH_RESET;
                activeNinth_r[i] <= 1'b0;
                reloadNinth_r[i] <= 1'b0;
                hitFlag_r[i]     <= 1'b0;
                pinOut_r[i]      <= 1'b0;
                activeCmp_r      <= cam_pkg::CMP_RESET;
            end
            else
            begin
                matchLow_r[i]    <= lowNxt;
                matchHigh_r[i]   <= highNxt;
                activeNinth_r[i] <= ninthNxt;
                if (auxWrEn[i])
                    reloadNinth_r[i] <= auxWrData[cam_pkg::AUX_RELOAD_BIT];
                hitFlag_r[i]     <= flagNxt;
                pinOut_r[i]      <= pinNxt;
                if (ovf)
                    activeCmp_r <= cmpDirect;
            end
        end

        a_cap_copy:
        assert property (@(posedge core_clk) disable iff (rst)
            captureEv[i] && !lowWrEn[i] && !highWrEn[i]
            |=> {matchHigh_r[i], matchLow_r[i]} == $past(counter_r))
        else $error("capture did not copy the counter");

        a_irq_gate:
        assert property (@(posedge core_clk) disable iff (rst)
            hitIrq[i] |-> hitFlag_r[i] && hitIrqEnable[i])
        else $error("interrupt request without flag and enable");

        a_flag_sticky:
        assert property (@(posedge core_clk) disable iff (rst)
            (hitSet || (hitFlag_r[i] && !hitFlagClr[i])) |=> hitFlag_r[i])
        else $error("hit flag lost before software cleared it");

        a_timer_hit:
        assert property (@(posedge core_clk) disable iff (rst)
            modeOf[i] == cam_pkg::MODE_TIMER && cntAdv_r &&
            counter_r == {matchHigh_r[i], matchLow_r[i]}
            |=> hitFlag_r[i])
        else $error("timer match did not set the hit flag");

        a_match_toggle:
        assert property (@(posedge core_clk) disable iff (rst)
            modeOf[i] == cam_pkg::MODE_TOGGLE_MATCH && hitEq
            |=> pinOut_r[i] != $past(pinOut_r[i]))
        else $error("pin did not toggle on match");

        a_pwm_level:
        assert property (@(posedge core_clk) disable iff (rst)
            modeOf[i] == cam_pkg::MODE_PWM && res8 && !useShadow
            |=> pinOut_r[i] == ($past(counter_r[7:0]) >=
                 $past(matchLow_r[i]) && !$past(activeNinth_r[i])))
        else $error("eight-bit PWM level wrong");

        a_reload_eight:
        assert property (@(posedge core_clk) disable iff (rst)
            reload8 && !lowWrEn[i] && !auxWrEn[i] && !fifoIntoLow && !bufIn
            |=> matchLow_r[i] == $past(matchHigh_r[i]) &&
                activeNinth_r[i] == $past(reloadNinth_r[i]))
        else $error("low-byte wrap did not reload the compare value");

        if (IS_ODD)
        begin : g_odd
            a_buf_capture:
            assert property (@(posedge core_clk) disable iff (rst)
                bufIn && !lowWrEn[i] && !captureEv[i]
                |=> matchLow_r[i] == $past(matchLow_r[P]))
            else $error("odd module did not buffer the even capture");
        end
        else
        begin : g_even
            a_fifo_step:
            assert property (@(posedge core_clk) disable iff (rst)
                fifoIntoHigh && !highWrEn[i]
                |=> matchHigh_r[i] == $past(matchLow_r[P]))
            else $error("FIFO step did not advance the queue");
        end

        if (!HAS_CAP)
        begin : g_nocap
            a_no_capture:
            assert property (@(posedge core_clk) disable iff (rst)
                !pwmish && !lowWrEn[i] && !highWrEn[i] && !fifoIntoLow
                |=> $stable({matchHigh_r[i], matchLow_r[i]}))
            else $error("capture on a module without capture");
        end
    end
endmodule // cam_modes

// *** sim/cam_pin_model.sv ***
// Model of the external signals on the eight module pins.
// Assumes the bench sets the level that the outside world drives.
`timescale 1ns/100ps
module cam_pin_model (
    input  wire logic [7:0] pinReq,
    input  wire logic [7:0] pinOut,
    input  wire logic [7:0] pinOe_n,
    output wire logic [7:0] pinLevel
);
    // The outside drives only where the module has let its pin go.
    assign pinLevel = (~pinOe_n & pinOut) | (pinOe_n & pinReq);
endmodule // cam_pin_model

// *** sim/tb_top.sv ***
// Self-checking bench for the counter array module modes.
// Assumes cam_modes, cam_pkg and the pin model are compiled before it.
`timescale 1ns/100ps
module tb_top;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        counterRun = 1'b0;
    logic [7:0]  ecom = 8'h00, rise = 8'h00, fall = 8'h00, mat = 8'h00;
    logic [7:0]  tog = 8'h00, pwm = 8'h00, irqEn = 8'h00, clr = 8'h00;
    logic [15:0] resSel = 16'h0000;
    logic [3:0]  bme = 4'h0;
    logic [3:0]  ovf = 4'h0;
    logic [1:0]  srcSel = 2'h0;
    logic [7:0]  wrData = 8'h00, lowWrEn = 8'h00, highWrEn = 8'h00;
    logic [7:0]  auxWrEn = 8'h00;
    logic [1:0]  auxWrData = 2'h0;
    logic [7:0]  pinReq = 8'h00;
    wire  [7:0]  pinLevel, pinOut, pinOe_n, hitFlag, hitIrq;
    wire  [7:0]  cntH, cntL, actN, relN;
    wire  [63:0] mLow, mHigh;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          hiCnt [8];
    int          flipCnt [8];
    logic [15:0] duty4 [4] = '{16'h0300, 16'h0100, 16'h0400, 16'h0000};

    initial forever #10 core_clk = ~core_clk;

    cam_modes i_cam_modes (
        .core_clk(core_clk), .rst(rst), .counterRun(counterRun),
        .comparatorEnable(ecom), .riseEdgeGrabEnable(rise),
        .fallEdgeGrabEnable(fall), .compareHitFlagEnable(mat),
        .pinFlipOnHit(tog), .pulseModEnable(pwm), .hitIrqEnable(irqEn),
        .pwmResolutionSel(resSel), .pair01BufferEnable(bme[0]),
        .pair23BufferEnable(bme[1]), .pair45BufferEnable(bme[2]),
        .pair67BufferEnable(bme[3]), .fifoStepSourceSel(srcSel),
        .timer0Overflow(ovf[0]), .timer1Overflow(ovf[1]),
        .timer3Overflow(ovf[2]), .serial0TimerOverflow(ovf[3]),
        .wrData(wrData), .lowWrEn(lowWrEn), .highWrEn(highWrEn),
        .auxWrEn(auxWrEn), .auxWrData(auxWrData), .hitFlagClr(clr),
        .modulePinIn(pinLevel), .modulePinOut(pinOut),
        .modulePinOe_n(pinOe_n), .matchLowOut(mLow), .matchHighOut(mHigh),
        .activeNinthOut(actN), .reloadNinthOut(relN), .hitFlag(hitFlag),
        .hitIrq(hitIrq), .counterHigh(cntH), .counterLow(cntL)
    );

    cam_pin_model i_cam_pin_model (
        .pinReq(pinReq), .pinOut(pinOut), .pinOe_n(pinOe_n),
        .pinLevel(pinLevel)
    );

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Byte write: kind 0 is the low match byte, kind 1 the high one.
    task automatic wr(input int k, input int n, input logic [7:0] d);
        wrData = d;
        if (k == 0)
            lowWrEn[n] = 1'b1;
        else
            highWrEn[n] = 1'b1;
        cyc(1);
        lowWrEn = 8'h00;
        highWrEn = 8'h00;
    endtask

    task automatic waitFlag(input int n);
        for (int i = 0; i < 20 && hitFlag[n] !== 1'b1; i++)
            cyc(1);
    endtask

    function automatic logic [15:0] cap(input int n);
        return {mHigh[8*n +: 8], mLow[8*n +: 8]};
    endfunction

    // Counts high cycles and changes of every pin over n cycles.
    task automatic measure(input int n);
        logic [7:0] last;
        last = pinOut;
        hiCnt = '{default: 0};
        flipCnt = '{default: 0};
        for (int i = 0; i < n; i++)
        begin
            cyc(1);
            for (int b = 0; b < 8; b++)
            begin
                hiCnt[b] += int'(pinOut[b] === 1'b1);
                flipCnt[b] += int'(pinOut[b] !== last[b]);
            end
            last = pinOut;
        end
    endtask

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (30000) @(posedge core_clk);
        n_fail++;
        final_report();
    end

    initial
    begin
        cyc(20);
        rst = 1'b0;
        chk({hitFlag, hitIrq}, 16'h0000);
        chk({cntH, cntL}, 16'h0000);
        counterRun = 1'b1;
        cyc(300);
        counterRun = 1'b0;
        cyc(2);
        chk({cntH, cntL}, 16'h012C);
        // Rising edge only, with interrupt enabled.
        rise[0] = 1'b1;
        rise[6] = 1'b1;
        irqEn[0] = 1'b1;
        pinReq = 8'h41;
        waitFlag(0);
        cyc(5);
        chk(cap(0), 16'h012C);
        chk({7'h00, hitIrq[0]}, 16'h0001);
        chk({7'h00, hitFlag[0]}, 16'h0001);
        chk({7'h00, hitFlag[6]}, 16'h0000);
        chk(cap(6), 16'h0000);
        clr[0] = 1'b1;
        cyc(1);
        clr[0] = 1'b0;
        pinReq = 8'h00;
        cyc(8);
        chk({hitFlag[0], hitIrq[0]}, 16'h0000);
        // Both edges with the pair buffer on.
        fall[0] = 1'b1;
        bme[0] = 1'b1;
        counterRun = 1'b1;
        cyc(10);
        counterRun = 1'b0;
        pinReq = 8'h01;
        waitFlag(0);
        cyc(2);
        chk(cap(0), 16'h0136);
        chk(cap(1), 16'h012C);
        // Falling edge only.
        rise[0] = 1'b0;
        counterRun = 1'b1;
        cyc(4);
        counterRun = 1'b0;
        pinReq = 8'h00;
        cyc(6);
        chk(cap(0), 16'h013A);
        chk(cap(1), 16'h0136);
        // Software timer on module 3, toggle on match on module 2.
        ecom[3:2] = 2'h3;
        mat[3:2] = 2'h3;
        tog[2] = 1'b1;
        wr(0, 2, 8'h40);
        wr(1, 2, 8'h01);
        wr(0, 3, 8'h40);
        wr(1, 3, 8'h01);
        chk({7'h00, pinOe_n[2]}, 16'h0000);
        chk({7'h00, pinOut[2]}, 16'h0000);
        counterRun = 1'b1;
        waitFlag(2);
        counterRun = 1'b0;
        cyc(2);
        chk({6'h00, hitFlag[3:2]}, 16'h0003);
        chk({6'h00, pinOut[3:2]}, 16'h0001);
        // PWM: module 4 buffered 8-bit, module 5 unbuffered 10-bit.
        ecom[5:4] = 2'b11;
        pwm[5:4] = 2'b11;
        resSel[11:8] = 4'b0100;
        wr(1, 5, 8'h01);
        wr(0, 5, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            wr(1, 4, k == 0 ? 8'h40 : k == 1 ? 8'hC0 : 8'h00);
            auxWrData = {k == 3, 1'b0};
            auxWrEn[4] = 1'b1;
            cyc(1);
            auxWrEn = 8'h00;
            counterRun = 1'b1;
            cyc(1100);
            measure(1024);
            chk(16'(hiCnt[4]), duty4[k]);
            chk(16'(hiCnt[5]), 16'h0300);
            counterRun = 1'b0;
        end
        // Buffered 10-bit PWM on module 4: a new duty waits for the wrap.
        bme[2] = 1'b1;
        resSel[9:8] = 2'h1;
        auxWrData = 2'h0;
        auxWrEn[4] = 1'b1;
        wr(1, 4, 8'h01);
        auxWrEn = 8'h00;
        wr(0, 4, 8'h00);
        counterRun = 1'b1;
        cyc(1100);
        for (int i = 0; i < 1100 && {cntH[1:0], cntL} != 10'h140; i++)
            cyc(1);
        counterRun = 1'b0;
        wr(0, 4, 8'h80);
        cyc(2);
        chk({7'h00, pinOut[4]}, 16'h0001);
        counterRun = 1'b1;
        cyc(1100);
        measure(1024);
        chk(16'(hiCnt[4]), 16'h0280);
        chk(16'(hiCnt[5]), 16'h0300);
        // PWM-match toggle on module 6, alone and paired with module 7.
        rise[6] = 1'b0;
        ecom[6] = 1'b1;
        tog[6] = 1'b1;
        pwm[6] = 1'b1;
        wr(1, 6, 8'h20);
        wr(0, 7, 8'h80);
        cyc(300);
        measure(256);
        chk(16'(flipCnt[6]), 16'h0001);
        bme[3] = 1'b1;
        cyc(300);
        measure(256);
        chk(16'(hiCnt[6]), 16'h0060);
        chk(16'(flipCnt[6]), 16'h0002);
        // FIFO stepping on module 0, one pass per step source.
        bme[0] = 1'b0;
        rise[0] = 1'b0;
        ecom[0] = 1'b1;
        pwm[0] = 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            srcSel = 2'(s);
            wr(0, 1, 8'h10 + 8'(s));
            wr(1, 1, 8'h20 + 8'(s));
            ovf[(s + 1) % 4] = 1'b1;
            cyc(1);
            ovf = 4'h0;
            cyc(2);
            chk({8'h00, mLow[15:8]}, {8'h00, 8'h10 + 8'(s)});
            ovf[s] = 1'b1;
            cyc(1);
            ovf = 4'h0;
            cyc(2);
            chk({8'h00, mHigh[7:0]}, {8'h00, 8'h10 + 8'(s)});
            chk({8'h00, mLow[15:8]}, {8'h00, 8'h20 + 8'(s)});
        end
        counterRun = 1'b1;
        cyc(300);
        chk({8'h00, mLow[7:0]}, 16'h0013);
        final_report();
    end
endmodule // tb_top
